// >>> core/pwdc_pkg.sv
// package: constants and carrier types for the pulse width and delay counter
package pwdc_pkg;

    // ------------------------------------------------------------------
    // counter layout
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W = 16;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_FULL = 16'hffff;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // ------------------------------------------------------------------
    // prescaler and clock selection
    // ------------------------------------------------------------------
    localparam int unsigned PRESC_W = 16;
    localparam int unsigned PSEL_W = 4;
    localparam int unsigned NUM_CK = 4;
    localparam logic [1:0] CKSEL_A = 2'h0;   // clk_sel_a
    localparam logic [1:0] CKSEL_B = 2'h2;   // clk_sel_b
    localparam logic [1:0] CKSEL_C = 2'h1;   // clk_sel_c, channels 1 and 3 only
    localparam logic [1:0] CKSEL_D = 2'h3;   // clk_sel_d, channels 1 and 3 only

    // ------------------------------------------------------------------
    // edge selection codes {edge_sel_hi, edge_sel_lo}
    // ------------------------------------------------------------------
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_LOW_W = 2'h2;   // low width / both edges
    localparam logic [1:0] EDGE_HIGH_W = 2'h3;  // high width / both edges

    // ------------------------------------------------------------------
    // noise filter
    // ------------------------------------------------------------------
    localparam int unsigned FILT_DEPTH = 3;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic {
        PWDC_MODE_WIDTH = 1'b0,
        PWDC_MODE_DELAY = 1'b1
    } pwdc_mode_t;

    typedef enum logic [2:0] {
        PWDC_IDLE = 3'b001,
        PWDC_WAIT = 3'b010,
        PWDC_COUNT = 3'b100
    } pwdc_state_t;

    typedef struct packed {
        pwdc_mode_t mode;
        logic [1:0] edge_sel;          // {edge_sel_hi, edge_sel_lo}
        logic [1:0] clk_sel;
        logic chan_filter_en;
        logic split_8bit;              // 8-bit timer mode on channels 1 and 3
    } pwdc_cfg_t;

endpackage

// >>> core/pwdc_filter.sv
// noise filter and edge detector for the timer input pin
module pwdc_filter
    import pwdc_pkg::*;
#(
    parameter int unsigned DEPTH = FILT_DEPTH
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic enable_in,
    input wire logic raw_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);

    logic [DEPTH-1:0] samp_reg;
    logic level_reg;
    logic level_next;

    // ------------------------------------------------------------------
    // sample history and filtered level
    // ------------------------------------------------------------------
    // with the filter enabled, the level moves only once all samples agree; disabled, it follows the newest sample
    always_comb
    begin
        level_next = level_reg;
        if (!enable_in)
            level_next = samp_reg[0];
        else if (&samp_reg)
            level_next = 1'b1;
        else if (~|samp_reg)
            level_next = 1'b0;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            samp_reg <= '0;
            level_reg <= 1'b0;
        end
        else if (clear_in)
        begin
            samp_reg <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            samp_reg <= {samp_reg[DEPTH-2:0], raw_in};
            level_reg <= level_next;
        end
    end

    // edge pulses are one cycle wide
    assign level_out = level_reg;
    assign rise_out = level_next & ~level_reg;
    assign fall_out = ~level_next & level_reg;

endmodule // pwdc_filter

// >>> core/pwdc_channel.sv
// one timer channel: pulse width measurement and one-shot delay counter
// Operation
// - start_trig in width mode arms, waits start edge
// - start edge clears counter, then counts up
// - capture edge copies counter, raises interrupt
// - overflow flag updated at every capture
// - after capture counter halts until start edge
// - stop_trig clears active, holds count and flag
// - unit disable resets all channel state
// - unit disabled ignores writes; enable leaves stopped
// - filter enable selects noise filter on input
// - prescaler sets four operation clock rates
// - delay mode: input edge starts down count
// - start_trig while active is software trigger
// - delay equals count period times data plus one
// - start triggers set matching active bits
// - delay trigger loads counter from data hold
// - zero count raises interrupt and stops
// - new data hold used from next period
// - channels 1 and 3 choose any clock in 8-bit mode
// - output level zero drives pin low
// - edge code 10 low width, 11 high
// - start_trig ignored while active in width mode
// - multiple full counts still set overflow
module pwdc_channel
    import pwdc_pkg::*;
#(
    parameter int unsigned CHAN_ID = 1
)
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic unit_enable_in,
    input wire logic [NUM_CK*PSEL_W-1:0] prescaler_select_in,
    input wire pwdc_cfg_t cfg_in,
    input wire logic start_trig_in,
    input wire logic start_trig_hi1_in,
    input wire logic start_trig_hi3_in,
    input wire logic stop_trig_in,
    input wire logic data_wr_in,
    input wire logic [CNT_W-1:0] data_wdata_in,
    input wire logic event_in,
    input wire logic out_level_bit_in,
    output logic [CNT_W-1:0] cnt_value_out,
    output logic [CNT_W-1:0] data_hold_out,
    output logic overflow_flag_out,
    output logic chan_active_out,
    output logic active_hi1_out,
    output logic active_hi3_out,
    output logic chan_irq_out,
    output logic [NUM_CK-1:0] clk_sel_tick_out,
    output logic to_pin_out,
    output logic to_oe_out
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    pwdc_state_t state_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic [NUM_CK-1:0] tick;
    logic [1:0] ck_idx;
    logic count_tick;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] data_reg;
    logic ovf_run_reg;
    logic ovf_reg;
    logic active_reg;
    logic hi1_reg;
    logic hi3_reg;
    logic irq_reg;
    logic pin_reg;
    logic ev_rise;
    logic ev_fall;
    logic width_mode;
    logic stop_ev;
    logic start_ev;
    logic start_first;
    logic w_start;
    logic w_cap;
    logic d_edge;
    logic d_trig;
    logic d_fire;
    logic is_split_chan;

    // picks the rising or the falling pulse
    function automatic logic edge_hit(input logic want_rise, input logic rise,
                                      input logic fall);
        edge_hit = want_rise ? rise : fall;
    endfunction

    // ------------------------------------------------------------------
    // prescaler: four operation clock enables
    // ------------------------------------------------------------------
    // free counter cleared while the unit is off
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            presc_reg <= '0;
        else if (!unit_enable_in)
            presc_reg <= '0;
        else
            presc_reg <= presc_reg + 1'b1;
    end

    // tick i fires once every 2**select cycles
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CK; gi++)
        begin : g_tick
            logic [PSEL_W-1:0] sel;
            logic [PRESC_W-1:0] mask;
            assign sel = prescaler_select_in[gi*PSEL_W +: PSEL_W];
            assign mask = PRESC_W'((32'h1 << sel) - 32'h1);
            assign tick[gi] = unit_enable_in & ((presc_reg & mask) == mask);
        end
    endgenerate

    // channels 1 and 3 in 8-bit mode may use clk_sel_c and clk_sel_d
    assign is_split_chan = (CHAN_ID == 1) || (CHAN_ID == 3);
    assign ck_idx = (is_split_chan && cfg_in.split_8bit) ? cfg_in.clk_sel
                                                        : {cfg_in.clk_sel[1], 1'b0};
    assign count_tick = tick[{ck_idx[0], ck_idx[1]}];
    assign clk_sel_tick_out = tick;

    // ------------------------------------------------------------------
    // input filter and edge detection
    // ------------------------------------------------------------------
    pwdc_filter #(
        .DEPTH(FILT_DEPTH)
    ) u_filter (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clear_in(~unit_enable_in),
        .enable_in(cfg_in.chan_filter_en),
        .raw_in(event_in),
        .level_out(),
        .rise_out(ev_rise),
        .fall_out(ev_fall)
    );

    // ------------------------------------------------------------------
    // channel events
    // ------------------------------------------------------------------
    // triggers count only while the unit is powered
    assign width_mode = (cfg_in.mode == PWDC_MODE_WIDTH);
    assign stop_ev = unit_enable_in & stop_trig_in;
    assign start_ev = unit_enable_in & start_trig_in & ~stop_trig_in;
    assign start_first = start_ev & ~active_reg;
    // high width starts on rise; low width starts on fall
    assign w_start = width_mode & unit_enable_in & (state_reg == PWDC_WAIT) & ~stop_ev &
                     edge_hit(cfg_in.edge_sel[0], ev_rise, ev_fall);
    assign w_cap = width_mode & unit_enable_in & (state_reg == PWDC_COUNT) & ~stop_ev &
                   edge_hit(~cfg_in.edge_sel[0], ev_rise, ev_fall);
    assign d_edge = cfg_in.edge_sel[1] ? (ev_rise | ev_fall)
                                       : edge_hit(cfg_in.edge_sel[0], ev_rise, ev_fall);
    assign d_trig = ~width_mode & active_reg & unit_enable_in & ~stop_ev &
                    (d_edge | start_ev);
    assign d_fire = ~width_mode & (state_reg == PWDC_COUNT) & count_tick &
                    (cnt_reg == CNT_ZERO) & ~d_trig & ~stop_ev;

    // ------------------------------------------------------------------
    // state and active bits
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_reg <= PWDC_IDLE;
        else if (!unit_enable_in || stop_ev)
            state_reg <= PWDC_IDLE;
        else if (start_first)
            state_reg <= PWDC_WAIT;
        else
        begin
            unique case (state_reg)
                PWDC_IDLE:
                    state_reg <= PWDC_IDLE;
                PWDC_WAIT:
                    if (w_start || d_trig)
                        state_reg <= PWDC_COUNT;
                PWDC_COUNT:
                    if (w_cap || d_fire)
                        state_reg <= PWDC_WAIT;
                default:
                    state_reg <= PWDC_IDLE;
            endcase
        end
    end

    // active bits set by triggers, cleared by stop or power off
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            active_reg <= 1'b0;
            hi1_reg <= 1'b0;
            hi3_reg <= 1'b0;
        end
        else if (!unit_enable_in || stop_ev)
        begin
            active_reg <= 1'b0;
            hi1_reg <= 1'b0;
            hi3_reg <= 1'b0;
        end
        else
        begin
            if (start_first)
                active_reg <= 1'b1;
            if (start_trig_hi1_in)
                hi1_reg <= 1'b1;
            if (start_trig_hi3_in)
                hi3_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cnt_reg <= CNT_ZERO;
        else if (!unit_enable_in)
            cnt_reg <= CNT_ZERO;
        else if (stop_ev)
            cnt_reg <= cnt_reg;
        else if (w_start)
            cnt_reg <= CNT_ZERO;
        else if (d_trig)
            cnt_reg <= data_reg;
        else if ((state_reg == PWDC_COUNT) && count_tick && !w_cap)
        begin
            if (width_mode)
                cnt_reg <= cnt_reg + 1'b1;
            else if (cnt_reg != CNT_ZERO)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // data hold: capture target or delay reload value
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            data_reg <= DATA_RST;
        else if (!unit_enable_in)
            data_reg <= DATA_RST;
        else if (w_cap)
            data_reg <= cnt_reg;
        else if (data_wr_in && !width_mode)
            data_reg <= data_wdata_in;
    end

    // ------------------------------------------------------------------
    // overflow tracking
    // ------------------------------------------------------------------
    // running flag sticks over any number of wraps in one interval
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ovf_run_reg <= 1'b0;
        else if (!unit_enable_in || w_start)
            ovf_run_reg <= 1'b0;
        else if (width_mode && (state_reg == PWDC_COUNT) && count_tick && !w_cap &&
                 !stop_ev && (cnt_reg == CNT_FULL))
            ovf_run_reg <= 1'b1;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ovf_reg <= 1'b0;
        else if (!unit_enable_in)
            ovf_reg <= 1'b0;
        else if (w_cap)
            ovf_reg <= ovf_run_reg;
    end

    // ------------------------------------------------------------------
    // interrupt pulse and output pin
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_reg <= 1'b0;
        else
            irq_reg <= w_cap | d_fire;
    end

    // counting never drives the pin: it shows the output level bit
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pin_reg <= 1'b0;
        else
            pin_reg <= unit_enable_in & out_level_bit_in;
    end

    assign cnt_value_out = cnt_reg;
    assign data_hold_out = data_reg;
    assign overflow_flag_out = ovf_reg;
    assign chan_active_out = active_reg;
    assign active_hi1_out = hi1_reg;
    assign active_hi3_out = hi3_reg;
    assign chan_irq_out = irq_reg;
    assign to_pin_out = pin_reg;
    assign to_oe_out = 1'b1;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    a_start_arms: assert property (start_first |=> chan_active_out &&
        state_reg == PWDC_WAIT) else $error("start did not arm channel");
    a_start_clear: assert property (w_start |=> cnt_value_out == CNT_ZERO)
        else $error("start edge did not clear counter");
    a_cap_copy: assert property (w_cap |=> chan_irq_out &&
        data_hold_out == $past(cnt_value_out)) else $error("capture value wrong");
    a_ovf_update: assert property (w_cap |=> overflow_flag_out ==
        $past(ovf_run_reg)) else $error("overflow flag not updated");
    a_halt_after: assert property (width_mode && w_cap ##1 !w_start && width_mode
        |=> $stable(cnt_value_out)) else $error("counter moved after capture");
    a_stop_hold: assert property (stop_ev |=> !chan_active_out &&
        cnt_value_out == $past(cnt_value_out) && overflow_flag_out == $past(ovf_reg))
        else $error("stop did not hold state");
    a_unit_off: assert property (!unit_enable_in |=> cnt_value_out == CNT_ZERO &&
        !chan_active_out && data_hold_out == DATA_RST) else $error("unit off not reset");
    a_active_ign: assert property (width_mode && start_ev && active_reg &&
        state_reg == PWDC_COUNT && !w_cap |=> state_reg == PWDC_COUNT)
        else $error("restart while active");
    a_delay_load: assert property (d_trig |=> cnt_value_out == $past(data_reg))
        else $error("delay load wrong");
    a_delay_zero: assert property (d_fire |=> chan_irq_out ##1 !chan_irq_out)
        else $error("terminal count pulse wrong");
    a_pin_low: assert property (!out_level_bit_in |=> !to_pin_out)
        else $error("pin not low");

    c_capture: cover property (w_cap);
    c_capture_ovf: cover property (w_cap && ovf_run_reg);
    c_delay_fire: cover property (d_fire);
    c_sw_trigger: cover property (d_trig && start_ev);

endmodule // pwdc_channel

// >>> tb/pwdc_pin_model.sv
// behavioural driver of the timer input pin seen by the channel
module pwdc_pin_model
(
    input wire logic clk_sys_in,
    output logic event_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // pin level, push-pull, always driven
    // ------------------------------------------------------------------
    initial event_out = 1'b0;

    // move the pin to a level at a falling edge
    task automatic set_level(input logic lvl);
        @(negedge clk_sys_in);
        event_out = lvl;
    endtask

    // invert the pin for n cycles, then put it back
    task automatic pulse(input int n);
        @(negedge clk_sys_in);
        event_out = ~event_out;
        repeat (n) @(negedge clk_sys_in);
        event_out = ~event_out;
    endtask
endmodule // pwdc_pin_model

// >>> tb/pulse_width_and_delay_counter_bench.sv
// self-checking bench for one pulse width and delay counter channel
`define chk(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end

module pulse_width_and_delay_counter_bench import pwdc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic unit_enable_in = 1'b0;
    logic [15:0] prescaler_select_in = 16'h0000;
    pwdc_cfg_t cfg_in = '0;
    logic [3:0] trig_vec = 4'h0;   // start, stop, hi1, hi3
    logic data_wr_in = 1'b0;
    logic [15:0] data_wdata_in = 16'h0000;
    logic event_in;
    logic out_level_bit_in = 1'b0;
    logic [15:0] cnt_value_out;
    logic [15:0] data_hold_out;
    logic overflow_flag_out;
    logic chan_active_out;
    logic active_hi1_out;
    logic active_hi3_out;
    logic chan_irq_out;
    logic [3:0] clk_sel_tick_out;
    logic to_pin_out;
    logic to_oe_out;
    int n_fail = 0;
    int check_count = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    pwdc_channel #(.CHAN_ID(1)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .unit_enable_in(unit_enable_in), .prescaler_select_in(prescaler_select_in),
        .cfg_in(cfg_in), .start_trig_in(trig_vec[0]), .start_trig_hi1_in(trig_vec[2]),
        .start_trig_hi3_in(trig_vec[3]), .stop_trig_in(trig_vec[1]), .data_wr_in(data_wr_in),
        .data_wdata_in(data_wdata_in), .event_in(event_in), .out_level_bit_in(out_level_bit_in),
        .cnt_value_out(cnt_value_out), .data_hold_out(data_hold_out),
        .overflow_flag_out(overflow_flag_out), .chan_active_out(chan_active_out),
        .active_hi1_out(active_hi1_out), .active_hi3_out(active_hi3_out),
        .chan_irq_out(chan_irq_out), .clk_sel_tick_out(clk_sel_tick_out),
        .to_pin_out(to_pin_out), .to_oe_out(to_oe_out));

    pwdc_pin_model model (.clk_sys_in(clk_sys_in), .event_out(event_in));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    // one-cycle trigger pulse: 0 start, 1 stop, 2 hi1, 3 hi3
    task automatic trig(input int k);
        @(negedge clk_sys_in);
        trig_vec = 4'h1 << k;
        @(negedge clk_sys_in);
        trig_vec = 4'h0;
    endtask

    task automatic wr_data(input logic [15:0] v);
        @(negedge clk_sys_in);
        data_wr_in = 1'b1;
        data_wdata_in = v;
        @(negedge clk_sys_in);
        data_wr_in = 1'b0;
    endtask

    // bounded wait for the interrupt pulse, n = cycles waited
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (chan_irq_out !== 1'b1 && n < lim)
        begin
            @(negedge clk_sys_in);
            n++;
        end
        `chk(n < lim, 1'b1)
    endtask

    // stop, set edge code and idle pin level while stopped, then start
    task automatic arm(input logic [1:0] es);
        trig(1);
        cfg_in.edge_sel = es;
        model.set_level(~es[0]);
        cyc(4);
        trig(0);
        cyc(2);
        `chk(chan_active_out, 1'b1)
    endtask

    // width measurement of a pulse of w cycles
    task automatic meas(input logic [1:0] es, input int w, input logic ovf);
        int n;
        logic [15:0] cv;
        arm(es);
        model.pulse(w);
        wait_irq(40, n);
        `chk(data_hold_out, 16'(w - 1))
        `chk(overflow_flag_out, ovf)
        `chk(to_pin_out, out_level_bit_in)
        cyc(1);
        `chk(chan_irq_out, 1'b0)
        cv = cnt_value_out;
        cyc(6);
        `chk(cnt_value_out, cv)
    endtask

    // software-triggered delay, new data written mid-count
    task automatic dly(input logic [15:0] d, input logic [15:0] nd, output int n);
        trig(0);
        `chk(cnt_value_out, d)
        wr_data(nd);
        wait_irq(1000, n);
        n = n + 3;
        cyc(2);
        `chk(cnt_value_out, CNT_ZERO)
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // watchdog: the run needs about 70k cycles, gives up at 90k
    // ------------------------------------------------------------------
    initial
    begin
        #1800000;
        n_fail++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int n;
        int n1;
        int n2;
        int w;
        int ticks [4];
        logic [15:0] d1;
        logic [15:0] d2;
        logic [15:0] cv;
        void'($urandom(82));
        cfg_in.split_8bit = 1'b1;
        cyc(8);
        rst_n_in = 1'b1;
        cyc(1);
        `chk({cnt_value_out, data_hold_out, overflow_flag_out, chan_active_out}, 34'h0)
        `chk(to_oe_out, 1'b1)
        unit_enable_in = 1'b1;
        cyc(2);
        $display("test reset done");
        // four tick rates from the prescaler nibbles
        for (int r = 0; r < 2; r++)
        begin
            prescaler_select_in = (r == 0) ? 16'h4321 : 16'($urandom) & 16'h5555;
            ticks = '{0, 0, 0, 0};
            for (int c = 0; c < 64; c++)
            begin
                @(negedge clk_sys_in);
                for (int i = 0; i < 4; i++)
                    ticks[i] += int'(clk_sel_tick_out[i]);
            end
            for (int i = 0; i < 4; i++)
                `chk(ticks[i], 64 >> prescaler_select_in[i*4 +: 4])
        end
        prescaler_select_in = 16'h4000;
        out_level_bit_in = 1'($urandom);
        cyc(2);
        `chk(to_pin_out, out_level_bit_in)
        out_level_bit_in = ~out_level_bit_in;
        cyc(2);
        `chk(to_pin_out, out_level_bit_in)
        trig(2);
        trig(3);
        cyc(1);
        `chk({active_hi1_out, active_hi3_out}, 2'h3)
        $display("test prescaler, pin, high triggers done");
        // high and low widths, shortest first
        meas(EDGE_HIGH_W, 1, 1'b0);
        meas(EDGE_HIGH_W, $urandom_range(300, 2), 1'b0);
        meas(EDGE_LOW_W, $urandom_range(300, 2), 1'b0);
        $display("test width done");
        // second start while counting changes nothing
        arm(EDGE_HIGH_W);
        model.set_level(1'b1);
        cyc(10);
        trig(0);
        cyc(10);
        model.set_level(1'b0);
        wait_irq(40, n);
        `chk(data_hold_out, 16'd22)
        // one wrap of the counter during the pulse
        w = 65536 + $urandom_range(50, 5);
        meas(EDGE_HIGH_W, w, 1'b1);
        // stop mid-count keeps count and flag
        arm(EDGE_HIGH_W);
        model.set_level(1'b1);
        cyc(20);
        trig(1);
        cyc(2);
        `chk(chan_active_out, 1'b0)
        cv = cnt_value_out;
        cyc(8);
        `chk(cnt_value_out, cv)
        `chk(overflow_flag_out, 1'b1)
        w = $urandom_range(100, 3);
        meas(EDGE_HIGH_W, w, 1'b0);
        $display("test overflow and stop done");
        // filter on: a one-cycle glitch is not an edge
        cfg_in.chan_filter_en = 1'b1;
        arm(EDGE_HIGH_W);
        model.pulse(1);
        cyc(12);
        `chk(data_hold_out, 16'(w - 1))
        meas(EDGE_HIGH_W, $urandom_range(200, 8), 1'b0);
        cfg_in.chan_filter_en = 1'b0;
        // fourth clock, period 16, on channel 1 in 8-bit mode; mode bits change only stopped
        trig(1);
        cfg_in.clk_sel = CKSEL_D;
        arm(EDGE_HIGH_W);
        model.pulse(160);
        wait_irq(60, n);
        `chk(data_hold_out >= 16'd8 && data_hold_out <= 16'd10, 1'b1)
        // without 8-bit mode the same code falls back to the second clock, every cycle
        trig(1);
        cfg_in.split_8bit = 1'b0;
        w = $urandom_range(60, 2);
        meas(EDGE_HIGH_W, w, 1'b0);
        $display("test filter and clock select done");
        // delay mode: every edge code starts a count
        trig(1);
        cfg_in.clk_sel = CKSEL_A;
        cfg_in.mode = PWDC_MODE_DELAY;
        model.set_level(1'b0);
        wr_data(16'h000a);
        trig(0);
        for (int e = 0; e < 4; e++)
        begin
            cfg_in.edge_sel = 2'(e);
            cyc(2);
            model.pulse(3);
            wait_irq(30, n);
            cyc(3);
            `chk(cnt_value_out, CNT_ZERO)
        end
        // software triggers; data written mid-count waits a period
        d1 = 16'($urandom_range(200, 8));
        d2 = 16'($urandom_range(400, 210));
        wr_data(d1);
        dly(d1, d2, n1);
        dly(d2, d2, n2);
        `chk(n2 - n1, int'(d2) - int'(d1))
        `chk(n1 >= int'(d1) + 1 && n1 <= int'(d1) + 3, 1'b1)
        $display("test delay done");
        // unit off clears everything and ignores writes
        unit_enable_in = 1'b0;
        cyc(2);
        `chk({cnt_value_out, data_hold_out, overflow_flag_out, chan_active_out}, 34'h0)
        wr_data(16'h1234);
        unit_enable_in = 1'b1;
        cyc(2);
        `chk({chan_active_out, data_hold_out}, 17'h0)
        $display("test unit enable done");
        give_verdict();
    end
endmodule // pulse_width_and_delay_counter_bench
